// *** verilog/pjs_sequencer.sv ***
// program jump and loop sequencer of the controller scan
`timescale 1ns/1ns
`default_nettype none
module pjs_sequencer #(
  parameter int TICK_CYC = pjs_pkg::TICK_1MS_CYC,
  parameter int MAX_MS = pjs_pkg::MAX_CYCLE_MS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // marker table load
  input wire logic tgt_clear_i,
  input wire logic tgt_wr_i,
  input wire logic [pjs_pkg::JNUM_W-1:0] tgt_num_i,
  input wire logic [pjs_pkg::ADDR_W-1:0] tgt_addr_i,
  // instruction stream
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire pjs_pkg::pjs_instr_s instr_i,
  // answer
  output logic resp_valid_o,
  output pjs_pkg::pjs_resp_s resp_o,
  // condition flags
  output logic error_flag_o,
  output logic equals_flag_o,
  output logic negative_flag_o,
  // scan supervision and timer ticks
  input wire logic scan_start_i,
  output logic cycle_too_long_o,
  output logic tick_1ms_o,
  output logic tick_10ms_o,
  output logic tick_100ms_o
);
  localparam int AW = pjs_pkg::ADDR_W;
  localparam int DW = pjs_pkg::DEPTH_W;
  localparam int LW = $bits(pjs_pkg::pjs_loop_s);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TGT = 2'b01,
    ST_TOP = 2'b10
  } pjs_state_e;

  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
    next_addr = a + 16'h0001;
  endfunction

  pjs_state_e state_reg;
  pjs_state_e state_next;
  pjs_pkg::pjs_instr_s hold_reg;
  logic [DW-1:0] depth_reg;
  logic [pjs_pkg::LOOP_DEPTH-1:0] repeat_reg;
  logic nop_active_reg;
  logic nop_pop_reg;
  logic [DW-1:0] nop_nest_reg;
  logic accept;
  logic tgt_rd_c;
  logic tgt_valid;
  logic [AW-1:0] tgt_addr;
  logic stk_rd_c;
  logic stk_wr_c;
  logic [DW-1:0] stk_wr_idx_c;
  pjs_pkg::pjs_loop_s stk_wdata_c;
  logic [LW-1:0] stk_rdata;
  pjs_pkg::pjs_loop_s top;
  logic resp_fire_c;
  pjs_pkg::pjs_resp_s resp_c;
  logic push_c;
  logic pop_c;
  logic loopback_c;
  logic nop_enter_c;
  logic nop_pop_c;
  logic nop_exit_c;
  logic nop_in_c;
  logic err_wr_c;
  logic err_c;
  logic eqn_clr_c;
  logic take;

  assign instr_ready_o = (state_reg == ST_IDLE);
  assign accept = instr_valid_i && instr_ready_o;
  assign top = pjs_pkg::pjs_loop_s'(stk_rdata);

  pjs_target_table u_table (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clear_i(tgt_clear_i),
    .wr_i(tgt_wr_i),
    .wr_num_i(tgt_num_i),
    .wr_addr_i(tgt_addr_i),
    .rd_i(tgt_rd_c),
    .rd_num_i(instr_i.operand[pjs_pkg::JNUM_W-1:0]),
    .rd_valid_o(tgt_valid),
    .rd_addr_o(tgt_addr)
  );

  pjs_loop_stack u_stack (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .wr_i(stk_wr_c),
    .wr_idx_i(stk_wr_idx_c),
    .wr_data_i(LW'(stk_wdata_c)),
    .rd_i(stk_rd_c),
    .rd_idx_i(depth_reg - 4'h1),
    .rd_data_o(stk_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decision logic

  // jump condition chosen from the instruction held during lookup
  always_comb begin
    if (hold_reg.op == pjs_pkg::OP_JUMP_ON_OFF) begin
      take = hold_reg.block || !hold_reg.cond;
    end else begin
      take = hold_reg.cond;
    end
  end

  always_comb begin
    state_next = state_reg;
    tgt_rd_c = 1'b0;
    stk_rd_c = 1'b0;
    stk_wr_c = 1'b0;
    stk_wr_idx_c = depth_reg;
    stk_wdata_c = '0;
    resp_fire_c = 1'b0;
    resp_c = '0;
    resp_c.edge_ok = ~|repeat_reg;
    push_c = 1'b0;
    pop_c = 1'b0;
    loopback_c = 1'b0;
    nop_enter_c = 1'b0;
    nop_pop_c = 1'b0;
    nop_exit_c = 1'b0;
    nop_in_c = 1'b0;
    err_wr_c = 1'b0;
    err_c = 1'b0;
    eqn_clr_c = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept && nop_active_reg) begin
          // body of a zero-count, overflowing or broken loop: nothing executes
          resp_fire_c = 1'b1;
          resp_c.no_operation = 1'b1;
          if (instr_i.op == pjs_pkg::OP_LOOP_START) begin
            nop_in_c = 1'b1;
          end else if (instr_i.op == pjs_pkg::OP_LOOP_END) begin
            nop_exit_c = 1'b1;
          end
        end else if (accept) begin
          resp_fire_c = 1'b1;
          unique case (instr_i.op)
            pjs_pkg::OP_JUMP_ON_OFF, pjs_pkg::OP_JUMP_ON_ON: begin
              if (instr_i.operand > pjs_pkg::JUMP_NUM_MAX) begin
                err_wr_c = 1'b1;
                err_c = 1'b1;
              end else begin
                resp_fire_c = 1'b0;
                tgt_rd_c = 1'b1;
                state_next = ST_TGT;
              end
            end
            pjs_pkg::OP_LOOP_START: begin
              err_wr_c = 1'b1;
              eqn_clr_c = 1'b1;
              if (depth_reg == pjs_pkg::DEPTH_FULL) begin
                err_c = 1'b1;
                nop_enter_c = 1'b1;
              end else if (instr_i.operand == pjs_pkg::COUNT_ZERO) begin
                nop_enter_c = 1'b1;
              end else begin
                push_c = 1'b1;
                stk_wr_c = 1'b1;
                stk_wdata_c.start = next_addr(instr_i.addr);
                stk_wdata_c.count = instr_i.operand;
                stk_wdata_c.task_id = instr_i.task_id;
              end
            end
            pjs_pkg::OP_LOOP_END: begin
              if (depth_reg != '0) begin
                resp_fire_c = 1'b0;
                stk_rd_c = 1'b1;
                state_next = ST_TOP;
              end
            end
            pjs_pkg::OP_LOOP_BREAK: begin
              if (instr_i.cond) begin
                err_wr_c = 1'b1;
                eqn_clr_c = 1'b1;
                if (depth_reg != '0) begin
                  nop_enter_c = 1'b1;
                  nop_pop_c = 1'b1;
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_TGT: begin
        state_next = ST_IDLE;
        resp_fire_c = 1'b1;
        err_wr_c = 1'b1;
        if (!tgt_valid) begin
          err_c = (hold_reg.op == pjs_pkg::OP_JUMP_ON_OFF);
        end else if (take) begin
          // fetch resumes at the marker: skipped words are never fetched
          resp_c.branch = 1'b1;
          resp_c.target = tgt_addr;
        end
      end
      ST_TOP: begin
        state_next = ST_IDLE;
        resp_fire_c = 1'b1;
        if (top.task_id != hold_reg.task_id) begin
          pop_c = 1'b1;
        end else if (top.count > pjs_pkg::COUNT_ONE) begin
          loopback_c = 1'b1;
          stk_wr_c = 1'b1;
          stk_wr_idx_c = depth_reg - 4'h1;
          stk_wdata_c = top;
          stk_wdata_c.count = top.count - pjs_pkg::COUNT_ONE;
          resp_c.branch = 1'b1;
          resp_c.target = top.start;
        end else begin
          pop_c = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      hold_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        hold_reg <= instr_i;
      end
    end
  end

  // loop depth and per-level repeat marks
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      depth_reg <= '0;
      repeat_reg <= '0;
    end else if (push_c) begin
      depth_reg <= depth_reg + 4'h1;
      repeat_reg[depth_reg] <= 1'b0;
    end else if (pop_c || (nop_exit_c && nop_nest_reg == '0 && nop_pop_reg)) begin
      depth_reg <= depth_reg - 4'h1;
      repeat_reg[depth_reg - 4'h1] <= 1'b0;
    end else if (loopback_c) begin
      // later passes of a level suppress edge instructions until the level pops
      repeat_reg[depth_reg - 4'h1] <= 1'b1;
    end
  end

  // no-operation region tracking, nested loop starts are counted through
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      nop_active_reg <= 1'b0;
      nop_pop_reg <= 1'b0;
      nop_nest_reg <= '0;
    end else if (nop_enter_c) begin
      nop_active_reg <= 1'b1;
      nop_pop_reg <= nop_pop_c;
      nop_nest_reg <= '0;
    end else if (nop_in_c) begin
      nop_nest_reg <= nop_nest_reg + 4'h1;
    end else if (nop_exit_c) begin
      if (nop_nest_reg == '0) begin
        nop_active_reg <= 1'b0;
        nop_pop_reg <= 1'b0;
      end else begin
        nop_nest_reg <= nop_nest_reg - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer and flags

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      resp_valid_o <= 1'b0;
      resp_o <= '0;
    end else begin
      resp_valid_o <= resp_fire_c;
      if (resp_fire_c) begin
        resp_o <= resp_c;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      error_flag_o <= pjs_pkg::ERR_RST;
      equals_flag_o <= pjs_pkg::EQ_RST;
      negative_flag_o <= pjs_pkg::NEG_RST;
    end else begin
      if (err_wr_c) begin
        error_flag_o <= err_c;
      end
      if (eqn_clr_c) begin
        equals_flag_o <= 1'b0;
        negative_flag_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer ticks and cycle watchdog

  // ticks run free of the program flow so timers in skipped code keep timing
  logic [$clog2(TICK_CYC)-1:0] div_reg;
  logic [3:0] dec10_reg;
  logic [3:0] dec100_reg;
  logic [$clog2(MAX_MS+1)-1:0] scan_ms_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      div_reg <= '0;
      tick_1ms_o <= 1'b0;
    end else if (div_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
      div_reg <= '0;
      tick_1ms_o <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      tick_1ms_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      dec10_reg <= '0;
      dec100_reg <= '0;
      tick_10ms_o <= 1'b0;
      tick_100ms_o <= 1'b0;
    end else begin
      tick_10ms_o <= 1'b0;
      tick_100ms_o <= 1'b0;
      if (tick_1ms_o) begin
        dec10_reg <= (dec10_reg == pjs_pkg::DECADE_LAST) ? 4'h0 : dec10_reg + 4'h1;
        if (dec10_reg == pjs_pkg::DECADE_LAST) begin
          tick_10ms_o <= 1'b1;
          dec100_reg <= (dec100_reg == pjs_pkg::DECADE_LAST) ? 4'h0 : dec100_reg + 4'h1;
          tick_100ms_o <= (dec100_reg == pjs_pkg::DECADE_LAST);
        end
      end
    end
  end

  // the error is fatal to the scan, so only reset clears it
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      scan_ms_reg <= '0;
      cycle_too_long_o <= 1'b0;
    end else begin
      if (scan_start_i) begin
        scan_ms_reg <= '0;
      end else if (tick_1ms_o && !cycle_too_long_o) begin
        scan_ms_reg <= scan_ms_reg + 1'b1;
      end
      if (scan_ms_reg >= ($clog2(MAX_MS+1))'(MAX_MS)) begin
        cycle_too_long_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** include/pjs_pkg.sv ***
// package: constants and carriers of the program jump and loop sequencer
package pjs_pkg;

  localparam int ADDR_W = 16;
  localparam int CNT_W = 16;
  localparam int TASK_W = 4;
  localparam int JNUM_W = 7;
  localparam int JUMP_NUMS = 128;
  localparam logic [CNT_W-1:0] JUMP_NUM_MAX = 16'h007F;
  localparam int LOOP_DEPTH = 15;
  localparam int DEPTH_W = 4;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'hF;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

  // flag reset values
  localparam logic ERR_RST = 1'b0;
  localparam logic EQ_RST = 1'b0;
  localparam logic NEG_RST = 1'b0;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int TICK_1MS_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam int MAX_CYCLE_MS = 1000;

  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_JUMP_ON_OFF = 3'b001,
    OP_JUMP_ON_ON = 3'b010,
    OP_JUMP_TARGET_MARKER = 3'b011,
    OP_LOOP_START = 3'b100,
    OP_LOOP_END = 3'b101,
    OP_LOOP_BREAK = 3'b110
  } pjs_op_e;

  typedef struct packed {
    logic [2:0] op;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] operand;
    logic cond;
    logic block;
    logic [TASK_W-1:0] task_id;
  } pjs_instr_s;

  typedef struct packed {
    logic branch;
    logic [ADDR_W-1:0] target;
    logic no_operation;
    logic edge_ok;
  } pjs_resp_s;

  typedef struct packed {
    logic [ADDR_W-1:0] start;
    logic [CNT_W-1:0] count;
    logic [TASK_W-1:0] task_id;
  } pjs_loop_s;

endpackage

// *** verilog/pjs_target_table.sv ***
// jump target table: lowest marker address per jump number
`timescale 1ns/1ns
`default_nettype none
module pjs_target_table #(
  parameter int NUMS = pjs_pkg::JUMP_NUMS,
  parameter int NUM_W = pjs_pkg::JNUM_W,
  parameter int AW = pjs_pkg::ADDR_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // program load side
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [NUM_W-1:0] wr_num_i,
  input wire logic [AW-1:0] wr_addr_i,
  // lookup side
  input wire logic rd_i,
  input wire logic [NUM_W-1:0] rd_num_i,
  output logic rd_valid_o,
  output logic [AW-1:0] rd_addr_o
);
  logic [AW-1:0] mem [NUMS];
  logic [NUMS-1:0] valid_reg;

  // markers arrive in rising address order, so the first one kept is the lowest
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || clear_i) begin
      valid_reg <= '0;
    end else if (wr_i && !valid_reg[wr_num_i]) begin
      valid_reg[wr_num_i] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr_i && !valid_reg[wr_num_i]) begin
      mem[wr_num_i] <= wr_addr_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_valid_o <= 1'b0;
      rd_addr_o <= '0;
    end else if (rd_i) begin
      rd_valid_o <= valid_reg[rd_num_i];
      rd_addr_o <= mem[rd_num_i];
    end
  end
endmodule
`default_nettype wire

// *** verilog/pjs_loop_stack.sv ***
// loop stack memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module pjs_loop_stack #(
  parameter int DEPTH = pjs_pkg::LOOP_DEPTH,
  parameter int IW = pjs_pkg::DEPTH_W,
  parameter int W = $bits(pjs_pkg::pjs_loop_s)
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // write port
  input wire logic wr_i,
  input wire logic [IW-1:0] wr_idx_i,
  input wire logic [W-1:0] wr_data_i,
  // read port
  input wire logic rd_i,
  input wire logic [IW-1:0] rd_idx_i,
  output logic [W-1:0] rd_data_o
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (wr_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_data_o <= '0;
    end else if (rd_i) begin
      rd_data_o <= mem[rd_idx_i];
    end
  end
endmodule
`default_nettype wire

// *** verification/pjs_sequencer_asserts.sv ***
// checker: port assertions of the jump and loop sequencer
`timescale 1ns/1ns
`default_nettype none
module pjs_seq_asserts (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  input wire pjs_pkg::pjs_instr_s instr_i,
  input wire logic resp_valid_o,
  input wire pjs_pkg::pjs_resp_s resp_o,
  // flags and supervision
  input wire logic error_flag_o,
  input wire logic equals_flag_o,
  input wire logic negative_flag_o,
  input wire logic cycle_too_long_o,
  input wire logic tick_1ms_o
);
  logic taken;
  logic is_jump;
  logic in_range;
  assign taken = instr_valid_i && instr_ready_o;
  assign is_jump = (instr_i.op == pjs_pkg::OP_JUMP_ON_OFF) || (instr_i.op == pjs_pkg::OP_JUMP_ON_ON);
  assign in_range = instr_i.operand <= pjs_pkg::JUMP_NUM_MAX;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////
  // jumps outside a no-operation region only; there the answer comes early
  a_range_error_set: assert property (taken && is_jump && !in_range |=> resp_valid_o && error_flag_o && !resp_o.branch)
    else $error("out-of-range jump number did not raise the error flag");
  a_jump_two_cycle: assert property (taken && is_jump && in_range |=> !instr_ready_o ##1 resp_valid_o)
    else $error("in-range jump answer not two cycles after acceptance");
  a_off_cond_on: assert property (taken && instr_i.op == pjs_pkg::OP_JUMP_ON_OFF && instr_i.cond && !instr_i.block
    && in_range |-> ##2 resp_valid_o && !resp_o.branch)
    else $error("jump-on-off with condition on branched");
  a_on_cond_off: assert property (taken && instr_i.op == pjs_pkg::OP_JUMP_ON_ON && !instr_i.cond && in_range
    |-> ##2 !resp_o.branch)
    else $error("jump-on-on with condition off branched");
  a_break_flags_off: assert property (taken && instr_i.op == pjs_pkg::OP_LOOP_BREAK && instr_i.cond
    |=> resp_valid_o && !error_flag_o && !equals_flag_o && !negative_flag_o)
    else $error("loop break left a flag on");
  a_loop_start_flags: assert property (taken && instr_i.op == pjs_pkg::OP_LOOP_START
    |=> resp_valid_o && !resp_o.branch && !equals_flag_o && !negative_flag_o)
    else $error("loop start answer or flags wrong");
  a_resp_has_cause: assert property (resp_valid_o |-> $past(taken, 1) || $past(taken, 2))
    else $error("answer without an accepted instruction");
  a_too_long_sticky: assert property (cycle_too_long_o |=> cycle_too_long_o)
    else $error("overlong cycle indication dropped");
  a_tick_single: assert property ($rose(tick_1ms_o) |=> !tick_1ms_o)
    else $error("millisecond tick longer than one cycle");
endmodule
bind pjs_sequencer pjs_seq_asserts pjs_seq_asserts_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .instr_i(instr_i), .resp_valid_o(resp_valid_o),
  .resp_o(resp_o), .error_flag_o(error_flag_o), .equals_flag_o(equals_flag_o), .negative_flag_o(negative_flag_o),
  .cycle_too_long_o(cycle_too_long_o), .tick_1ms_o(tick_1ms_o));
`default_nettype wire

// *** verification/pjs_sequencer_bench.sv ***
// bench: self-checking run of the jump and loop sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module pjs_sequencer_bench;
  localparam logic [2:0] OTH = pjs_pkg::OP_OTHER;
  localparam logic [2:0] JOFF = pjs_pkg::OP_JUMP_ON_OFF;
  localparam logic [2:0] JON = pjs_pkg::OP_JUMP_ON_ON;
  localparam logic [2:0] LST = pjs_pkg::OP_LOOP_START;
  localparam logic [2:0] LEND = pjs_pkg::OP_LOOP_END;
  localparam logic [2:0] BRK = pjs_pkg::OP_LOOP_BREAK;
  logic sys_clk_i, nrst_i, tgt_clear_i, tgt_wr_i, instr_valid_i, instr_ready_o, resp_valid_o, scan_start_i;
  logic [pjs_pkg::JNUM_W-1:0] tgt_num_i;
  logic [pjs_pkg::ADDR_W-1:0] tgt_addr_i;
  pjs_pkg::pjs_instr_s instr_i;
  pjs_pkg::pjs_resp_s resp_o;
  logic error_flag_o, equals_flag_o, negative_flag_o, cycle_too_long_o, tick_1ms_o, tick_10ms_o, tick_100ms_o;
  int errors;
  int num_checks;
  // short tick and watchdog figures keep the run small
  pjs_sequencer #(.TICK_CYC(10), .MAX_MS(3)) pjs_sequencer_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .tgt_clear_i(tgt_clear_i), .tgt_wr_i(tgt_wr_i), .tgt_num_i(tgt_num_i), .tgt_addr_i(tgt_addr_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .instr_i(instr_i), .resp_valid_o(resp_valid_o),
    .resp_o(resp_o), .error_flag_o(error_flag_o), .equals_flag_o(equals_flag_o), .negative_flag_o(negative_flag_o),
    .scan_start_i(scan_start_i), .cycle_too_long_o(cycle_too_long_o), .tick_1ms_o(tick_1ms_o),
    .tick_10ms_o(tick_10ms_o), .tick_100ms_o(tick_100ms_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    `CHK("ready", 1'b1, instr_ready_o)
    `CHK("error", 1'b0, error_flag_o)
  endtask
  task automatic mark(input logic [6:0] n, input logic [15:0] a);
    tgt_num_i <= n;
    tgt_addr_i <= a;
    @(posedge sys_clk_i);
  endtask
  // number 5 markers go in rising address order; the later number 5 entry must lose
  task automatic load_markers();
    tgt_clear_i <= 1'b1;
    @(posedge sys_clk_i);
    tgt_clear_i <= 1'b0;
    tgt_wr_i <= 1'b1;
    mark(7'h05, 16'h0020);
    mark(7'h05, 16'h0030);
    mark(7'h09, 16'h0008);
    tgt_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic issue(input logic [2:0] op, input logic [15:0] a, input logic [15:0] opd, input logic c,
      input logic b, input logic [3:0] t);
    int n;
    n = 0;
    instr_valid_i <= 1'b1;
    instr_i <= '{op, a, opd, c, b, t};
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b0;
    @(posedge sys_clk_i);
    while (resp_valid_o !== 1'b1) begin
      n++;
      if (n > 4) begin
        errors++;
        give_verdict();
      end
      @(posedge sys_clk_i);
    end
  endtask
  task automatic jc(input logic [2:0] op, input logic [15:0] num, input logic c, input logic b,
      input logic br, input logic [15:0] tg, input logic er);
    issue(op, 16'h0010, num, c, b, 4'h0);
    `CHK("branch", br, resp_o.branch)
    if (br) `CHK("target", tg, resp_o.target)
    `CHK("error", er, error_flag_o)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_watch();
    int n;
    scan_start_i <= 1'b1;
    @(posedge sys_clk_i);
    scan_start_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    `CHK("too long early", 1'b0, cycle_too_long_o)
    for (n = 0; n < 40 && cycle_too_long_o !== 1'b1; n++) @(posedge sys_clk_i);
    `CHK("too long late", 1'b1, cycle_too_long_o)
  endtask
  task automatic t_jumps();
    jc(JOFF, 16'h0005, 1'b0, 1'b0, 1'b1, 16'h0020, 1'b0);
    jc(JOFF, 16'h0005, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    jc(JOFF, 16'h0005, 1'b1, 1'b1, 1'b1, 16'h0020, 1'b0);
    jc(JON, 16'h0005, 1'b1, 1'b0, 1'b1, 16'h0020, 1'b0);
    jc(JON, 16'h0005, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
    jc(JON, 16'h0005, 1'b0, 1'b1, 1'b0, 16'h0000, 1'b0);
    jc(JOFF, 16'h0009, 1'b0, 1'b0, 1'b1, 16'h0008, 1'b0);
    jc(JOFF, 16'h0007, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
    jc(JON, 16'h0080, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b1);
    jc(JON, 16'h007F, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
  endtask
  task automatic t_loop();
    issue(LST, 16'h0040, 16'h0002, 1'b0, 1'b0, 4'h1);
    issue(OTH, 16'h0041, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("edge first pass", 1'b1, resp_o.edge_ok)
    issue(LEND, 16'h0042, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("repeat", 1'b1, resp_o.branch)
    `CHK("repeat target", 16'h0041, resp_o.target)
    issue(OTH, 16'h0041, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("edge second pass", 1'b0, resp_o.edge_ok)
    issue(LEND, 16'h0042, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("loop done", 1'b0, resp_o.branch)
  endtask
  task automatic t_zero();
    issue(LST, 16'h0050, 16'h0000, 1'b0, 1'b0, 4'h1);
    issue(OTH, 16'h0051, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("zero body", 1'b1, resp_o.no_operation)
    issue(LEND, 16'h0052, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("zero end", 1'b0, resp_o.branch)
    issue(OTH, 16'h0053, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("after zero", 1'b0, resp_o.no_operation)
  endtask
  // break in the inner of two loops; the outer one must carry on
  task automatic t_break();
    issue(LST, 16'h0060, 16'h0001, 1'b0, 1'b0, 4'h1);
    issue(LST, 16'h0061, 16'h0003, 1'b0, 1'b0, 4'h1);
    issue(JON, 16'h0062, 16'h0080, 1'b1, 1'b0, 4'h1);
    `CHK("error before break", 1'b1, error_flag_o)
    issue(BRK, 16'h0063, 16'h0000, 1'b1, 1'b0, 4'h1);
    `CHK("break error", 1'b0, error_flag_o)
    `CHK("break equals", 1'b0, equals_flag_o)
    `CHK("break negative", 1'b0, negative_flag_o)
    issue(OTH, 16'h0064, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("after break", 1'b1, resp_o.no_operation)
    issue(LEND, 16'h0065, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("inner end", 1'b0, resp_o.branch)
    issue(OTH, 16'h0066, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("outer alive", 1'b0, resp_o.no_operation)
    issue(LEND, 16'h0067, 16'h0000, 1'b0, 1'b0, 4'h1);
    `CHK("outer end", 1'b0, resp_o.branch)
  endtask
  task automatic t_split();
    issue(LST, 16'h0070, 16'h0002, 1'b0, 1'b0, 4'h1);
    issue(LEND, 16'h0071, 16'h0000, 1'b0, 1'b0, 4'h2);
    `CHK("split loop", 1'b0, resp_o.branch)
  endtask
  task automatic t_nest();
    for (int i = 0; i < 15; i++) begin
      issue(LST, 16'h0080 + 16'(i), 16'h0002, 1'b0, 1'b0, 4'h1);
      `CHK("nest ok", 1'b0, error_flag_o)
    end
    issue(LST, 16'h008F, 16'h0002, 1'b0, 1'b0, 4'h1);
    `CHK("nest deep", 1'b1, error_flag_o)
    do_reset();
  endtask
  task automatic t_ticks();
    int n1, n10, n100;
    n1 = 0;
    n10 = 0;
    n100 = 0;
    // the first 10 ms tick comes one cycle past 100 and the first 100 ms tick one cycle past 1000 after reset
    repeat (5) @(posedge sys_clk_i);
    repeat (1000) begin
      @(posedge sys_clk_i);
      n1 += int'(tick_1ms_o === 1'b1);
      n10 += int'(tick_10ms_o === 1'b1);
      n100 += int'(tick_100ms_o === 1'b1);
    end
    `CHK("ms ticks", 100, n1)
    `CHK("10ms ticks", 10, n10)
    `CHK("100ms ticks", 1, n100)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    errors = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    tgt_clear_i = 1'b0;
    tgt_wr_i = 1'b0;
    tgt_num_i = '0;
    tgt_addr_i = '0;
    instr_valid_i = 1'b0;
    instr_i = '0;
    scan_start_i = 1'b0;
    do_reset();
    t_watch();
    load_markers();
    t_jumps();
    t_loop();
    t_zero();
    t_break();
    t_split();
    t_nest();
    t_ticks();
    give_verdict();
  end
endmodule
`default_nettype wire
